//--- core/bod_defines.svh
// register map, field positions and reset values of the bulk out dma block
`ifndef BOD_DEFINES_SVH
`define BOD_DEFINES_SVH
// =====================================================================
// register offsets: channel c sits at c * 0x10, offsets within a channel, then the absolute addresses of the shared registers
`define BOD_OFS_CTRL   4'h0
`define BOD_OFS_PKT    4'h4
`define BOD_OFS_SLOT   4'h8
`define BOD_ADR_CPCFG  8'h20
`define BOD_ADR_EPCFG  8'h24
`define BOD_ADR_EPSTAT 8'h28
// =====================================================================
// field positions
`define BOD_CTRL_ON    0
`define BOD_CTRL_HSK   1
`define BOD_CTRL_DIR   2
`define BOD_CTRL_EP    4
`define BOD_CTRL_BUSY  8
`define BOD_SLOT_B2    16
`define BOD_CP_AC97    0
`define BOD_CP_BLK     1
// =====================================================================
// reset values and codec frame timing
`define BOD_RST_WORD   32'h0000_0000
`define BOD_SLOT_BITS  16
`endif

//--- core/bod_pkg.sv
// types shared by the bulk out dma block
package bod_pkg;
    // channel sequencer states, one-hot
    typedef enum logic [4:0] {
        CH_OFF   = 5'b00001,
        CH_PICK  = 5'b00010,
        CH_FILL  = 5'b00100,
        CH_LATCH = 5'b01000,
        CH_HOLD  = 5'b10000
    } bod_ch_state_t;
    typedef logic [2:0] bod_ep_t;
endpackage : bod_pkg

//--- core/bod_dma_chan.sv
// one dma channel: drains endpoint buffers into codec slot words
module bod_dma_chan #(
    parameter int CNT_W = 16
) (
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    // configuration
    input  wire logic             chOn,
    input  wire logic             hskMode,
    input  wire logic             bytes2,
    input  wire logic [CNT_W-1:0] pktInit,
    // state of the served endpoint
    input  wire logic             nackX,
    input  wire logic             nackY,
    input  wire logic             toggle,
    input  wire logic             dblBuf,
    input  wire logic [7:0]       cntX,
    input  wire logic [7:0]       cntY,
    // buffer read port, data one cycle after rdEn
    output logic                  rdEn,
    output logic                  rdBufY,
    output logic [7:0]            rdOffs,
    input  wire logic [7:0]       rdData,
    // codec slot word
    input  wire logic             take,
    output logic                  wordVld,
    output logic [15:0]           word,
    // completion and status
    output logic                  clrNackX,
    output logic                  clrNackY,
    output logic                  doneIrq,
    output logic                  busy,
    output logic [CNT_W-1:0]      remain
);
    import bod_pkg::*;

    if (CNT_W < 1 || CNT_W > 16) begin : g_bad_cnt_w
        $error("CNT_W out of range");
    end

    bod_ch_state_t    st_q, st_d;
    logic             bufY_q, bufY_d, vld_q, vld_d, nb_q, nb_d;
    logic [7:0]       left_q, left_d, offs_q, offs_d;
    logic [15:0]      word_q, word_d;
    logic [CNT_W-1:0] rem_q, rem_d;

    // =================================================================
    // sequencer next state
    always_comb begin
        st_d = st_q; bufY_d = bufY_q; vld_d = vld_q; nb_d = nb_q;
        left_d = left_q; offs_d = offs_q; word_d = word_q; rem_d = rem_q;
        rdEn = 1'b0; clrNackX = 1'b0; clrNackY = 1'b0; doneIrq = 1'b0;
        if (!chOn) begin
            st_d = CH_OFF;
            vld_d = 1'b0;
        end else begin
            unique case (st_q)
                CH_OFF: begin
                    rem_d = pktInit;
                    st_d = CH_PICK;
                end
                CH_PICK: if (nackX || (dblBuf && nackY)) begin
                    bufY_d = dblBuf && nackY && (!nackX || toggle);
                    left_d = bufY_d ? cntY : cntX;
                    offs_d = 8'h00;
                    nb_d = 1'b0;
                    word_d = 16'h0000;
                    st_d = CH_FILL;
                end
                CH_FILL: if (left_q == 8'h00) begin
                    st_d = CH_HOLD;
                end else begin
                    rdEn = 1'b1;
                    st_d = CH_LATCH;
                end
                CH_LATCH: begin
                    word_d = nb_q ? {word_q[15:8], rdData} : {rdData, 8'h00};
                    offs_d = offs_q + 8'h01;
                    left_d = left_q - 8'h01;
                    nb_d = 1'b1;
                    st_d = CH_FILL;
                    if (!bytes2 || nb_q || left_q == 8'h01) begin
                        vld_d = 1'b1;
                        nb_d = 1'b0;
                        st_d = CH_HOLD;
                    end
                end
                CH_HOLD: if (!vld_q || take) begin
                    vld_d = 1'b0;
                    word_d = 16'h0000;
                    st_d = CH_FILL;
                    if (left_q == 8'h00) begin
                        clrNackX = !bufY_q;
                        clrNackY = bufY_q;
                        st_d = CH_PICK;
                        if (hskMode) begin
                            rem_d = rem_q - 1'b1;
                            if (rem_q == {{(CNT_W-1){1'b0}}, 1'b1}) begin
                                doneIrq = 1'b1;
                                st_d = CH_OFF;
                            end
                        end
                    end
                end
            endcase
        end
    end

    // sequencer registers
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_q <= CH_OFF; bufY_q <= 1'b0; vld_q <= 1'b0; nb_q <= 1'b0;
            left_q <= 8'h00; offs_q <= 8'h00; word_q <= 16'h0000;
            rem_q <= '0;
        end else begin
            st_q <= st_d; bufY_q <= bufY_d; vld_q <= vld_d; nb_q <= nb_d;
            left_q <= left_d; offs_q <= offs_d; word_q <= word_d;
            rem_q <= rem_d;
        end
    end

    assign rdBufY = bufY_q;
    assign rdOffs = offs_q;
    assign wordVld = vld_q;
    assign word = word_q;
    assign busy = (st_q != CH_OFF);
    assign remain = rem_q;

    // =================================================================
    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    property p_done_last;
        doneIrq |-> hskMode && rem_q == {{(CNT_W-1){1'b0}}, 1'b1};
    endproperty
    a_done_last: assert property (p_done_last) else $error("early done");
    property p_dx_no_done;
        !hskMode |-> !doneIrq;
    endproperty
    a_dx_no_done: assert property (p_dx_no_done) else $error("done in dx");
    property p_pick_nack;
        (st_q == CH_PICK ##1 st_q == CH_FILL) |-> $past(nackX || nackY);
    endproperty
    a_pick_nack: assert property (p_pick_nack) else $error("empty pick");
    property p_pick_older;
        st_q == CH_PICK && chOn && dblBuf && nackX && nackY |=> bufY_q == $past(toggle);
    endproperty
    a_pick_older: assert property (p_pick_older) else $error("wrong buf");
    property p_rem_dec;
        (clrNackX || clrNackY) && hskMode |=> rem_q == $past(rem_q) - 1'b1;
    endproperty
    a_rem_dec: assert property (p_rem_dec) else $error("count stuck");
    c_done: cover property (doneIrq);
endmodule : bod_dma_chan

//--- core/bod_bulk_out_dma.sv
// bulk out dma: two channels, endpoint flags, codec serializer, ahb registers
//
// Summary of operation
// - handshake bit set: run programmed packet count
// - handshake bit clear: forward packets until disabled
// - no data: drop sync or clear slot tags
// - packet count register, up to 64K packets
// - packet stored: toggle if double buffered, set nack, count, interrupt
// - nack flag set means buffer holds data
// - double buffer: pick from both nacks and toggle
// - channel clears nack after whole buffer sent
// - endpoint interrupt on every stored packet
// - handshake run done: self disable, completion interrupt
// - channels never serve in-direction endpoints
// - exactly two channels, buffers to codec only
`include "bod_defines.svh"
module bod_bulk_out_dma #(
    parameter int NSLOT = 14,
    parameter int CNT_W = 16
) (
    // clock and reset
    input  wire logic          ref_clk,
    input  wire logic          rst_n,
    // ahb-lite slave
    input  wire logic          hsel,
    input  wire logic [31:0]   haddr,
    input  wire logic [1:0]    htrans,
    input  wire logic          hwrite,
    input  wire logic [2:0]    hsize,
    input  wire logic [31:0]   hwdata,
    input  wire logic          hready,
    output logic               hreadyout,
    output logic               hresp,
    output logic [31:0]        hrdata,
    // packet store events from the usb side
    input  wire logic          pktStore,
    input  wire bod_pkg::bod_ep_t pktEp,
    input  wire logic [7:0]    pktCount,
    output logic [7:0]         outEpIrq,
    // endpoint buffer read ports, channel c in slice c
    output logic [1:0]         bufRdEn,
    output logic [5:0]         bufRdEp,
    output logic [1:0]         bufRdY,
    output logic [15:0]        bufRdOffs,
    input  wire logic [15:0]   bufRdData,
    // codec port
    input  wire logic          csclk,
    output logic               cdSync,
    output logic               cdData,
    // per-channel completion
    output logic [1:0]         channelDoneIrq
);
    import bod_pkg::*;

    if (NSLOT < 2 || NSLOT > 14) begin : g_bad_nslot
        $error("NSLOT out of range");
    end

    // =================================================================
    // register state
    logic [1:0]       on_q, on_d, hsk_q, hsk_d, dir_q, dir_d, b2_q, b2_d;
    bod_ep_t          ep_q [2];
    bod_ep_t          ep_d [2];
    logic [CNT_W-1:0] pkt_q [2];
    logic [CNT_W-1:0] pkt_d [2];
    logic [13:0]      mask_q [2];
    logic [13:0]      mask_d [2];
    logic             ac97_q, ac97_d, blk_q, blk_d;
    logic [7:0]       dbl_q, dbl_d;
    logic [7:0]       aAddr_q;
    logic             aMap_q, wrPh_q, rdPh_q;
    logic [31:0]      rdata_q, rdMux;
    // buffer manager state
    logic [7:0]       nx_q, nx_d, ny_q, ny_d, tg_q, tg_d, irq_q, irq_d;
    logic [7:0]       cx_q [8];
    logic [7:0]       cx_d [8];
    logic [7:0]       cy_q [8];
    logic [7:0]       cy_d [8];
    // channel signals
    logic [1:0]       chClrX, chClrY, chDone, chBusy, chVld, chTake;
    logic [15:0]      chWord [2];
    logic [CNT_W-1:0] chRem [2];
    logic             wrCyc;

    assign wrCyc = wrPh_q && aMap_q;

    // =================================================================
    // two channels, each serving one out endpoint
    for (genvar c = 0; c < 2; c++) begin : g_ch
        bod_dma_chan #(.CNT_W(CNT_W)) u_ch (
            .ref_clk  (ref_clk),
            .rst_n    (rst_n),
            .chOn     (on_q[c]),
            .hskMode  (hsk_q[c]),
            .bytes2   (b2_q[c]),
            .pktInit  (pkt_q[c]),
            .nackX    (nx_q[ep_q[c]]),
            .nackY    (ny_q[ep_q[c]]),
            .toggle   (tg_q[ep_q[c]]),
            .dblBuf   (dbl_q[ep_q[c]]),
            .cntX     (cx_q[ep_q[c]]),
            .cntY     (cy_q[ep_q[c]]),
            .rdEn     (bufRdEn[c]),
            .rdBufY   (bufRdY[c]),
            .rdOffs   (bufRdOffs[8*c +: 8]),
            .rdData   (bufRdData[8*c +: 8]),
            .take     (chTake[c]),
            .wordVld  (chVld[c]),
            .word     (chWord[c]),
            .clrNackX (chClrX[c]),
            .clrNackY (chClrY[c]),
            .doneIrq  (chDone[c]),
            .busy     (chBusy[c]),
            .remain   (chRem[c])
        );
        assign bufRdEp[3*c +: 3] = ep_q[c];
    end

    // =================================================================
    // ahb address phase capture; reads take one wait state
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            aAddr_q <= 8'h00; aMap_q <= 1'b0; wrPh_q <= 1'b0; rdPh_q <= 1'b0;
            rdata_q <= `BOD_RST_WORD;
        end else begin
            wrPh_q <= 1'b0;
            rdPh_q <= 1'b0;
            if (hsel && hready && htrans[1]) begin
                aAddr_q <= haddr[7:0];
                aMap_q <= (haddr[31:8] == 24'h00_0000) && (haddr[1:0] == 2'b00);
                wrPh_q <= hwrite;
                rdPh_q <= !hwrite;
            end
            if (rdPh_q) rdata_q <= aMap_q ? rdMux : `BOD_RST_WORD;
        end
    end
    assign hreadyout = !rdPh_q;
    assign hresp = 1'b0;
    assign hrdata = rdata_q;

    // read data multiplexer
    always_comb begin
        rdMux = `BOD_RST_WORD;
        for (int c = 0; c < 2; c++) begin
            if (aAddr_q[7:4] == 4'(c)) begin
                unique case (aAddr_q[3:0])
                    `BOD_OFS_CTRL: begin
                        rdMux[`BOD_CTRL_ON] = on_q[c];
                        rdMux[`BOD_CTRL_HSK] = hsk_q[c];
                        rdMux[`BOD_CTRL_DIR] = dir_q[c];
                        rdMux[`BOD_CTRL_EP +: 3] = ep_q[c];
                        rdMux[`BOD_CTRL_BUSY] = chBusy[c];
                    end
                    `BOD_OFS_PKT: rdMux[CNT_W-1:0] = chRem[c];
                    `BOD_OFS_SLOT: begin
                        rdMux[13:0] = mask_q[c];
                        rdMux[`BOD_SLOT_B2] = b2_q[c];
                    end
                    default: ;
                endcase
            end
        end
        if (aAddr_q == `BOD_ADR_CPCFG) begin
            rdMux[`BOD_CP_AC97] = ac97_q;
            rdMux[`BOD_CP_BLK] = blk_q;
        end
        if (aAddr_q == `BOD_ADR_EPCFG) rdMux[15:0] = {tg_q, dbl_q};
        if (aAddr_q == `BOD_ADR_EPSTAT) rdMux[23:0] = {tg_q, ny_q, nx_q};
    end

    // =================================================================
    // configuration registers next values; software write wins over self clear
    always_comb begin
        on_d = on_q; hsk_d = hsk_q; dir_d = dir_q; b2_d = b2_q;
        ep_d = ep_q; pkt_d = pkt_q; mask_d = mask_q;
        ac97_d = ac97_q; blk_d = blk_q; dbl_d = dbl_q;
        for (int c = 0; c < 2; c++) begin
            if (chDone[c]) on_d[c] = 1'b0;
            if (wrCyc && aAddr_q[7:4] == 4'(c)) begin
                unique case (aAddr_q[3:0])
                    `BOD_OFS_CTRL: begin
                        hsk_d[c] = hwdata[`BOD_CTRL_HSK];
                        dir_d[c] = hwdata[`BOD_CTRL_DIR];
                        ep_d[c] = hwdata[`BOD_CTRL_EP +: 3];
                        on_d[c] = hwdata[`BOD_CTRL_ON] && !hwdata[`BOD_CTRL_DIR];
                    end
                    `BOD_OFS_PKT: pkt_d[c] = hwdata[CNT_W-1:0];
                    `BOD_OFS_SLOT: begin
                        mask_d[c] = hwdata[13:0];
                        b2_d[c] = hwdata[`BOD_SLOT_B2];
                    end
                    default: ;
                endcase
            end
        end
        if (wrCyc && aAddr_q == `BOD_ADR_CPCFG) begin
            ac97_d = hwdata[`BOD_CP_AC97];
            blk_d = hwdata[`BOD_CP_BLK];
        end
        if (wrCyc && aAddr_q == `BOD_ADR_EPCFG) dbl_d = hwdata[7:0];
    end

    // =================================================================
    // buffer manager flags: clears first, packet store sets last
    always_comb begin
        nx_d = nx_q; ny_d = ny_q; tg_d = tg_q; cx_d = cx_q; cy_d = cy_q;
        irq_d = 8'h00;
        for (int c = 0; c < 2; c++) begin
            if (chClrX[c]) nx_d[ep_q[c]] = 1'b0;
            if (chClrY[c]) ny_d[ep_q[c]] = 1'b0;
        end
        if (wrCyc && aAddr_q == `BOD_ADR_EPSTAT) begin
            nx_d = nx_d & ~hwdata[7:0];
            ny_d = ny_d & ~hwdata[15:8];
        end
        if (wrCyc && aAddr_q == `BOD_ADR_EPCFG) tg_d = hwdata[15:8];
        if (pktStore) begin
            if (dbl_q[pktEp] && tg_d[pktEp]) begin
                ny_d[pktEp] = 1'b1;
                cy_d[pktEp] = pktCount;
            end else begin
                nx_d[pktEp] = 1'b1;
                cx_d[pktEp] = pktCount;
            end
            if (dbl_q[pktEp]) tg_d[pktEp] = !tg_d[pktEp];
            irq_d[pktEp] = 1'b1;
        end
    end

    // register and flag storage
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            on_q <= 2'b00; hsk_q <= 2'b00; dir_q <= 2'b00; b2_q <= 2'b00;
            ep_q <= '{default: 3'h0}; pkt_q <= '{default: '0};
            mask_q <= '{default: 14'h0000};
            ac97_q <= 1'b0; blk_q <= 1'b0; dbl_q <= 8'h00;
            nx_q <= 8'h00; ny_q <= 8'h00; tg_q <= 8'h00; irq_q <= 8'h00;
            cx_q <= '{default: 8'h00}; cy_q <= '{default: 8'h00};
        end else begin
            on_q <= on_d; hsk_q <= hsk_d; dir_q <= dir_d; b2_q <= b2_d;
            ep_q <= ep_d; pkt_q <= pkt_d; mask_q <= mask_d;
            ac97_q <= ac97_d; blk_q <= blk_d; dbl_q <= dbl_d;
            nx_q <= nx_d; ny_q <= ny_d; tg_q <= tg_d; irq_q <= irq_d;
            cx_q <= cx_d; cy_q <= cy_d;
        end
    end
    assign outEpIrq = irq_q;
    assign channelDoneIrq = chDone;

    // =================================================================
    // codec serializer on the sampled link clock
    logic        cs1_q, cs2_q, cs3_q, edgeR, anyData, frameStart;
    logic        sync_q, sync_d, data_q, data_d;
    logic [3:0]  bit_q, bit_d, slot_q, slot_d;
    logic [15:0] sh_q, sh_d, slotWord, tag;
    logic [1:0]  own;

    assign edgeR = cs2_q && !cs3_q;
    assign anyData = |chVld;
    assign frameStart = edgeR && bit_q == 4'h0 && slot_q == 4'h0;

    // slot ownership and ac97 tag word
    always_comb begin
        own[0] = mask_q[0][slot_q];
        own[1] = mask_q[1][slot_q] && !own[0];
        tag = 16'h0000;
        tag[15] = anyData;
        for (int s = 1; s < 13; s++) begin
            if (s < NSLOT) tag[15-s] = |({mask_q[1][s], mask_q[0][s]} & chVld);
        end
        if (ac97_q && slot_q == 4'h0) slotWord = tag;
        else if (own[0] && chVld[0]) slotWord = chWord[0];
        else if (own[1] && chVld[1]) slotWord = chWord[1];
        else slotWord = 16'h0000;
        chTake = (edgeR && bit_q == 4'h0 && !(ac97_q && slot_q == 4'h0)) ? own : 2'b00;
    end

    // bit and slot counters, shift register, sync
    always_comb begin
        bit_d = bit_q; slot_d = slot_q; sh_d = sh_q; data_d = data_q; sync_d = sync_q;
        if (edgeR) begin
            bit_d = bit_q + 4'h1;
            sync_d = 1'b0;
            if (bit_q == 4'h0) begin
                sh_d = {slotWord[14:0], 1'b0};
                data_d = slotWord[15];
                if (slot_q == 4'h0) sync_d = ac97_q || !blk_q || anyData;
            end else begin
                sh_d = {sh_q[14:0], 1'b0};
                data_d = sh_q[15];
            end
            if (bit_q == 4'(`BOD_SLOT_BITS - 1)) begin
                slot_d = (slot_q == 4'(NSLOT - 1)) ? 4'h0 : slot_q + 4'h1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cs1_q <= 1'b0; cs2_q <= 1'b0; cs3_q <= 1'b0;
            bit_q <= 4'h0; slot_q <= 4'h0; sh_q <= 16'h0000;
            data_q <= 1'b0; sync_q <= 1'b0;
        end else begin
            cs1_q <= csclk; cs2_q <= cs1_q; cs3_q <= cs2_q;
            bit_q <= bit_d; slot_q <= slot_d; sh_q <= sh_d;
            data_q <= data_d; sync_q <= sync_d;
        end
    end
    assign cdSync = sync_q;
    assign cdData = data_q;

    // =================================================================
    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    property p_store_nack;
        pktStore && !dbl_q[pktEp] |=> nx_q[$past(pktEp)];
    endproperty
    a_store_nack: assert property (p_store_nack) else $error("nack not set");
    property p_store_irq;
        pktStore |=> outEpIrq[$past(pktEp)] ##1 ($past(pktStore) || !outEpIrq[$past(pktEp, 2)]);
    endproperty
    a_store_irq: assert property (p_store_irq) else $error("irq missing");
    property p_done_off;
        chDone[0] && !wrCyc |=> !on_q[0];
    endproperty
    a_done_off: assert property (p_done_off) else $error("still on");
    property p_no_in;
        on_q[1] |-> !dir_q[1];
    endproperty
    a_no_in: assert property (p_no_in) else $error("in endpoint run");
    property p_gp_nosync;
        frameStart && !ac97_q && blk_q && !anyData |=> !cdSync;
    endproperty
    a_gp_nosync: assert property (p_gp_nosync) else $error("sync w/o data");
    c_both_on: cover property (on_q == 2'b11);
    c_ac97_frame: cover property (frameStart && ac97_q && anyData);
    c_dbl_store: cover property (pktStore && dbl_q[pktEp] && nx_q[pktEp]);
endmodule : bod_bulk_out_dma

//--- tb/bod_codec_model.sv
// far device on the codec port: makes the bit clock, collects slot 0 words
module bod_codec_model (
    // bit clock, runs only while the far device is ready
    input  wire logic   run,
    output logic        csclk,
    // serial frame from the block
    input  wire logic   cdSync,
    input  wire logic   cdData,
    // collected words
    output int          nWords,
    output logic [15:0] lastWord
);
    timeunit 1ns;
    timeprecision 1ns;
    int          idx;
    logic [15:0] sh;
    // 320 ns bit clock, held low outside a run
    initial begin
        csclk = 1'b0;
        nWords = 0;
        idx = 16;
        forever #160 csclk = run ? ~csclk : 1'b0;
    end
    // sample on the rising edge, the block moves data well away from it
    always @(posedge csclk) begin
        if (cdSync) begin
            idx = 1;
            sh = {cdData, 15'h0000};
        end else if (idx < 16) begin
            sh[15-idx] = cdData;
            idx = idx + 1;
            if (idx == 16) begin
                nWords = nWords + 1;
                lastWord = sh;
            end
        end
    end
endmodule : bod_codec_model

//--- tb/bod_bulk_out_dma_tb_top.sv
// self-checking bench of the bulk out dma block
module bod_bulk_out_dma_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import bod_pkg::*;
    logic        ref_clk, rst_n, hsel, hwrite, hreadyout, hresp, pktStore, csclk, cdSync, cdData;
    logic        run;
    logic [31:0] haddr, hwdata, hrdata, d;
    logic [1:0]  htrans, bufRdEn, bufRdY, channelDoneIrq;
    logic [2:0]  hsize = 3'h2;
    wire logic   hready = hreadyout;
    logic [7:0]  pktCount, outEpIrq, dbase;
    logic [5:0]  bufRdEp;
    logic [15:0] bufRdOffs, bufRdData, lastWord;
    bod_ep_t     pktEp, ep;
    int          failures, n_tests, nWords, k, nRd;
    bod_bulk_out_dma #(.NSLOT(2)) u_bod_bulk_out_dma (
        .ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pktStore(pktStore),
        .pktEp(pktEp), .pktCount(pktCount), .outEpIrq(outEpIrq), .bufRdEn(bufRdEn),
        .bufRdEp(bufRdEp), .bufRdY(bufRdY), .bufRdOffs(bufRdOffs), .bufRdData(bufRdData),
        .csclk(csclk), .cdSync(cdSync), .cdData(cdData), .channelDoneIrq(channelDoneIrq)
    );
    bod_codec_model u_bod_codec_model (
        .run(run), .csclk(csclk), .cdSync(cdSync), .cdData(cdData), .nWords(nWords),
        .lastWord(lastWord)
    );
    // count buffer reads of channel 0
    always @(posedge ref_clk)
        if (bufRdEn[0] === 1'b1) nRd++;
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    // endpoint buffer: y bytes differ from x bytes in the top bit
    function automatic logic [7:0] bv(input logic [7:0] o, input logic y);
        return o + {y, 7'h00} + dbase;
    endfunction
    always @(posedge ref_clk)
        bufRdData <= {bv(bufRdOffs[15:8], bufRdY[1]), bv(bufRdOffs[7:0], bufRdY[0])};
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        n_tests++;
        if (s !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    // one ahb single transfer, waits on hready in both phases
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        do @(negedge ref_clk); while (hreadyout !== 1'b1);
        @(posedge ref_clk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(negedge ref_clk); while (hreadyout !== 1'b1);
        d = hrdata;
        chk("hresp", 32'h0000_0000, {31'h0000_0000, hresp});
        @(posedge ref_clk);
    endtask
    task automatic store(input bod_ep_t e, input logic [7:0] c);
        pktStore <= 1'b1;
        pktEp <= e;
        pktCount <= c;
        @(posedge ref_clk);
        pktStore <= 1'b0;
        @(negedge ref_clk);
        chk("outEpIrq", 8'h01 << e, outEpIrq);
        @(posedge ref_clk);
    endtask
    task automatic waitWords(input int n);
        for (k = 0; k < 30000 && nWords < n; k++) @(posedge ref_clk);
        chk("words", n, nWords);
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #2_000_000;
        failures++;
        conclude;
    end
    initial begin
        void'($urandom(32'h4962_66b9));
        {hsel, hwrite, htrans, haddr, hwdata, pktStore, pktEp, pktCount, run, rst_n} = '0;
        dbase = 8'($urandom);
        ep = bod_ep_t'(1 + $urandom % 7);
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        xfer(1'b0, 32'h0000_0000, 32'h0000_0000);
        chk("ctrl0 reset", 32'h0000_0000, d);
        xfer(1'b1, 32'h0000_0010, 32'h0000_0015);
        xfer(1'b0, 32'h0000_0010, 32'h0000_0000);
        chk("ctrl1 in", 32'h0000_0014, d);
        xfer(1'b0, 32'h0000_003c, 32'h0000_0000);
        chk("unmapped", 32'h0000_0000, d);
        $display("test registers done");
        xfer(1'b1, 32'h0000_0020, 32'h0000_0002);
        xfer(1'b1, 32'h0000_0008, 32'h0001_0001);
        xfer(1'b1, 32'h0000_0024, 32'h0000_0001 << ep);
        xfer(1'b1, 32'h0000_0004, 32'h0000_0002);
        store(ep, 8'h02);
        store(ep, 8'h02);
        xfer(1'b0, 32'h0000_0028, 32'h0000_0000);
        chk("nacks", 32'h0000_0101 << ep, d);
        run <= 1'b1;
        xfer(1'b1, 32'h0000_0000, 32'h0000_0003 | (32'(ep) << 4));
        for (k = 0; k < 20000 && channelDoneIrq[0] !== 1'b1; k++) @(negedge ref_clk);
        chk("done irq", 32'h0000_0001, {30'h0000_0000, channelDoneIrq});
        chk("rd ep", 32'(ep), {29'h0000_0000, bufRdEp[2:0]});
        @(posedge ref_clk);
        waitWords(2);
        repeat (1000) @(posedge ref_clk);
        waitWords(2);
        chk("y word", {bv(8'h00, 1'b1), bv(8'h01, 1'b1)}, lastWord);
        xfer(1'b0, 32'h0000_0000, 32'h0000_0000);
        chk("ctrl0 off", 32'h0000_0002 | (32'(ep) << 4), d);
        xfer(1'b0, 32'h0000_0004, 32'h0000_0000);
        chk("remain", 32'h0000_0000, d);
        xfer(1'b0, 32'h0000_0028, 32'h0000_0000);
        chk("nack clear", 32'h0000_0000, d);
        $display("test handshake done");
        xfer(1'b1, 32'h0000_0024, 32'h0000_0000);
        xfer(1'b1, 32'h0000_0000, 32'h0000_0001 | (32'(ep) << 4));
        repeat (3) begin
            store(ep, 8'h01);
            for (k = 0; k < 300; k++) begin
                xfer(1'b0, 32'h0000_0028, 32'h0000_0000);
                if (d[ep] !== 1'b1) break;
            end
            chk("nack", 32'h0000_0000, d);
        end
        waitWords(5);
        chk("pad word", {bv(8'h00, 1'b0), 8'h00}, lastWord);
        xfer(1'b0, 32'h0000_0000, 32'h0000_0000);
        chk("still on", 32'h0000_0001, d & 32'h0000_0001);
        $display("test direct done");
        xfer(1'b1, 32'h0000_0008, 32'h0000_0002);
        xfer(1'b1, 32'h0000_0020, 32'h0000_0001);
        store(ep, 8'h01);
        for (k = 0; k < 3000 && lastWord !== 16'hc000; k++) @(posedge ref_clk);
        chk("ac97 tag", 32'h0000_c000, {16'h0000, lastWord});
        waitWords(nWords + 1);
        chk("idle tag", 32'h0000_0000, {16'h0000, lastWord});
        chk("reads", 32'h0000_0008, nRd);
        $display("test ac97 done");
        conclude;
    end
endmodule : bod_bulk_out_dma_tb_top
